//--- detect_timer.sv
// detector clock prescaler and intermittent detection cycle timer
`default_nettype none
module detect_timer
	import svm_pkg::*;
#(
	parameter int unsigned PRESCALE = PRESCALE_DEF
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// control
	input  wire logic       run,
	input  wire logic       clear,
	input  wire logic [1:0] mode,
	// timing pulses
	output logic            det_tick,
	output logic            sample
);
	localparam int unsigned PW = $clog2(PRESCALE);

	logic [PW-1:0] pre_q;
	logic [8:0]    cyc_q;
	logic [8:0]    period;
	logic          pre_end;

	// detection cycle length from the mode code
	always_comb begin
		case (mode)
			MODE_I128: period = PERIOD_128;
			MODE_I256: period = PERIOD_256;
			MODE_I512: period = PERIOD_512;
			default:   period = PERIOD_128;
		endcase
	end

	assign pre_end = (pre_q == PW'(PRESCALE - 1));

	// divider down to the detector clock rate
	always_ff @(posedge clk) begin
		if (!rst_b || !run || clear) begin
			pre_q    <= '0;
			det_tick <= 1'b0;
		end else begin
			pre_q    <= pre_end ? '0 : pre_q + PW'(1);
			det_tick <= pre_end;
		end
	end

	// detection cycle counter, one sample per cycle
	always_ff @(posedge clk) begin
		if (!rst_b || !run || clear || mode == MODE_CONT) begin
			cyc_q  <= '0;
			sample <= 1'b0;
		end else if (det_tick) begin
			cyc_q  <= (cyc_q == period) ? '0 : cyc_q + 9'h001;
			sample <= (cyc_q == period);
		end else begin
			sample <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- supply_sense_model.sv
// behavioural comparator facing the monitor control block
`default_nettype none
module supply_sense_model (
	// clock
	input  wire logic       clk,
	// settings from the control block
	input  wire logic       enable,
	input  wire logic       source_sel,
	input  wire logic [4:0] threshold,
	// supply levels as threshold codes
	input  wire logic [4:0] main_level,
	input  wire logic [4:0] ext_level,
	// comparator output
	output logic            below
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] lvl;

	// source routing
	assign lvl = source_sel ? ext_level : main_level;
	initial below = 1'b0;
	// compare when powered, toggle meaninglessly when off
	always @(posedge clk) begin
		if (enable) begin
			below <= lvl < threshold;
		end else begin
			below <= !below;
		end
	end
endmodule
`default_nettype wire

//--- supply_voltage_monitor_ctrl.sv
// control logic of the supply voltage detector with its register file
//
// Overview of operation
// - intermittent mode triggers after 1, 2, 4 or 8 successive lows per count code
// - continuous mode ignores the successive count setting
// - five-bit threshold selects one of 30 levels, 0x01 to 0x1e
// - reset key 0xa turns a detection into a reset request, else interrupt
// - mode 0 continuous, 1..3 sample every 128, 256, 512 detector clocks
// - detection runs only while the enable bit is 1
// - disabling resets the detector, keeps settings; enable reads 0 when done
// - changing count, key or mode while enabled reinitialises the detector
// - status bit 8 reads 1 while voltage is under the threshold
// - flag bit 0 set on interrupt cause, cleared by writing 1
// - clearing the flag while enabled also reinitialises the detector
// - interrupt enable bit 0 gates the detection interrupt
// - with reset key 0xa no interrupt is issued
// - source select routes main supply at 0, external sense pin at 1
// - flag sets on each low in continuous mode, on reaching count otherwise
// - interrupt request only while flag and interrupt enable are both 1
// - flag stays set after the voltage recovers until software clears it
//
// Chosen here: the placing of the registers and the strobed register port.
`default_nettype none
module supply_voltage_monitor_ctrl
	import svm_pkg::*;
#(
	parameter int unsigned PRESCALE = PRESCALE_DEF
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic      [DATA_W-1:0] rd_data,
	// analogue comparator
	input  wire logic              cmp_below,
	output logic                   monitored_source_select,
	output logic      [4:0]        threshold_level,
	output logic                   comparator_enable,
	// requests to interrupt controller and reset logic
	output logic                   low_voltage_irq,
	output logic                   reset_req
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	run_state_e  state_q;
	logic        src_q;
	logic [1:0]  cnt_sel_q;
	logic [4:0]  thr_q;
	logic [3:0]  key_q;
	logic [1:0]  mode_q;
	logic        flag_q;
	logic        ien_q;
	logic        sync1_q;
	logic        sync2_q;
	logic        sync3_q;
	logic        below_q;
	logic [3:0]  low_cnt_q;
	logic [1:0]  stop_cnt_q;
	logic        rst_hold_q;
	logic        running;
	logic        wr_ctl;
	logic        wr_sts;
	logic        wr_ien;
	logic [1:0]  new_cnt;
	logic [3:0]  new_key;
	logic [1:0]  new_mode;
	logic        cfg_change;
	logic        flag_clear;
	logic        reinit;
	logic        det_tick;
	logic        sample;
	logic        hit;
	logic        trigger;
	logic        is_reset;
	logic        timer_run;
	logic        timer_clear;

	// successive low count needed for a trigger
	function automatic logic [3:0] count_target(input logic [1:0] sel);
		case (sel)
			2'h0:    count_target = CNT_ONCE;
			2'h1:    count_target = CNT_TWICE;
			2'h2:    count_target = CNT_FOUR;
			default: count_target = CNT_EIGHT;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	assign wr_ctl   = wr_en && (addr == ADDR_CTL);
	assign wr_sts   = wr_en && (addr == ADDR_STS);
	assign wr_ien   = wr_en && (addr == ADDR_IEN);
	assign new_key  = wr_data[CTL_KEY_LO +: 4];
	assign new_mode = wr_data[CTL_MODE_LO +: 2];
	// count field only accepted when the written mode is intermittent
	assign new_cnt  = (new_mode != MODE_CONT) ? wr_data[CTL_CNT_LO +: 2] : cnt_sel_q;
	assign running  = (state_q == ST_RUN);
	assign is_reset = (key_q == RESET_KEY);

	// reinitialise on setting changes or a flag clear while running
	assign cfg_change = wr_ctl && !rst_hold_q && ((new_cnt != cnt_sel_q) ||
		(new_key != key_q) || (new_mode != mode_q));
	assign flag_clear = wr_sts && wr_data[STS_FLAG];
	assign reinit     = running && (cfg_change || flag_clear);

	// ----------------------------------------------------------------
	// enable sequencing
	// ----------------------------------------------------------------
	// disable passes through a stop phase that clears the detector
	// the enable bit keeps reading 1 until the stop phase is over
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= ST_OFF;
		end else begin
			case (state_q)
				ST_OFF: begin
					if (wr_ctl && wr_data[CTL_EN])
						state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (wr_ctl && !wr_data[CTL_EN])
						state_q <= ST_STOP;
				end
				ST_STOP: begin
					// writes of 1 here are ignored until the bit reads 0
					if (det_tick && stop_cnt_q == STOP_TICKS - 2'h1)
						state_q <= ST_OFF;
				end
				default: state_q <= ST_OFF;
			endcase
		end
	end

	// stop phase length in detector clocks
	always_ff @(posedge clk) begin
		if (!rst_b || state_q != ST_STOP)
			stop_cnt_q <= '0;
		else if (det_tick)
			stop_cnt_q <= stop_cnt_q + 2'h1;
	end

	// ----------------------------------------------------------------
	// control register settings
	// ----------------------------------------------------------------
	// settings kept across disable; reset hold forces continuous mode
	// a reset trigger drops back to continuous mode with count zero
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			src_q     <= 1'b0;
			cnt_sel_q <= CNT_RESET;
			thr_q     <= THR_RESET;
			key_q     <= KEY_RESET;
			mode_q    <= MODE_CONT;
		end else if (trigger && is_reset) begin
			cnt_sel_q <= CNT_RESET;
			mode_q    <= MODE_CONT;
		end else if (wr_ctl && !rst_hold_q) begin
			src_q     <= wr_data[CTL_SRC];
			cnt_sel_q <= new_cnt;
			thr_q     <= wr_data[CTL_THR_LO +: 5];
			key_q     <= new_key;
			mode_q    <= new_mode;
		end
	end

	// interrupt enable, cleared while a reset is being issued
	always_ff @(posedge clk) begin
		if (!rst_b)
			ien_q <= 1'b0;
		else if (trigger && is_reset)
			ien_q <= 1'b0;
		else if (wr_ien)
			ien_q <= wr_data[IEN_BIT];
	end

	// ----------------------------------------------------------------
	// comparator input
	// ----------------------------------------------------------------
	// three stage synchroniser, accepted when last two stages agree
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			below_q <= 1'b0;
		end else begin
			sync1_q <= cmp_below;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (!running)
				below_q <= 1'b0;
			else if (sync2_q == sync3_q)
				below_q <= sync3_q;
		end
	end

	// ----------------------------------------------------------------
	// detection
	// ----------------------------------------------------------------
	// timer keeps ticking through the stop phase in every mode,
	// otherwise a disable in continuous mode never finishes
	assign timer_run   = (state_q != ST_OFF);
	assign timer_clear = reinit;

	detect_timer #(
		.PRESCALE (PRESCALE)
	) u_timer (
		.clk      (clk),
		.rst_b    (rst_b),
		.run      (timer_run),
		.clear    (timer_clear),
		.mode     (mode_q),
		.det_tick (det_tick),
		.sample   (sample)
	);

	// successive low counter, restarted by a high sample
	always_ff @(posedge clk) begin
		if (!rst_b || !running || reinit || mode_q == MODE_CONT)
			low_cnt_q <= '0;
		else if (sample && !below_q)
			low_cnt_q <= '0;
		else if (sample && hit)
			low_cnt_q <= '0;
		else if (sample)
			low_cnt_q <= low_cnt_q + 4'h1;
	end

	// trigger: every low in continuous mode, on target count otherwise
	assign hit     = (low_cnt_q + 4'h1 == count_target(cnt_sel_q));
	assign trigger = running && !reinit && below_q &&
		((mode_q == MODE_CONT) || (sample && hit));

	// sticky flag, a clear wins since it blocks a new cause in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_b)
			flag_q <= 1'b0;
		else if (trigger)
			flag_q <= 1'b1;
		else if (flag_clear)
			flag_q <= 1'b0;
	end

	// reset request held until the voltage recovers
	// control writes other than the enable bit stay locked while it is held
	always_ff @(posedge clk) begin
		if (!rst_b)
			rst_hold_q <= 1'b0;
		else if (trigger && is_reset)
			rst_hold_q <= 1'b1;
		else if (!below_q)
			rst_hold_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// request and comparator control outputs
	// all registered, one cycle behind the internal state
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			low_voltage_irq         <= 1'b0;
			reset_req               <= 1'b0;
			monitored_source_select <= 1'b0;
			threshold_level         <= THR_RESET;
			comparator_enable       <= 1'b0;
		end else begin
			low_voltage_irq         <= flag_q && ien_q && !is_reset;
			reset_req               <= rst_hold_q || (trigger && is_reset);
			monitored_source_select <= src_q;
			threshold_level         <= thr_q;
			comparator_enable       <= running;
		end
	end

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk) begin
		if (!rst_b || !rd_en) begin
			rd_data <= '0;
		end else begin
			rd_data <= '0;
			case (addr)
				ADDR_CTL: begin
					rd_data[CTL_SRC]             <= src_q;
					rd_data[CTL_CNT_LO +: 2]     <= cnt_sel_q;
					rd_data[CTL_THR_LO +: 5]     <= thr_q;
					rd_data[CTL_KEY_LO +: 4]     <= key_q;
					rd_data[CTL_MODE_LO +: 2]    <= mode_q;
					rd_data[CTL_EN]              <= (state_q != ST_OFF);
				end
				ADDR_STS: begin
					rd_data[STS_BELOW] <= below_q;
					rd_data[STS_FLAG]  <= flag_q;
				end
				ADDR_IEN: rd_data[IEN_BIT] <= ien_q;
				default:  rd_data <= '0;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- supply_voltage_monitor_ctrl_tb.sv
// self-checking bench for the supply voltage monitor control block
`default_nettype none
module supply_voltage_monitor_ctrl_tb import svm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PS = 4;
	logic        clk, rst_b, wr_en, rd_en, below, src, cmp_en, irq, rreq;
	logic [1:0]  addr;
	logic [15:0] wr_data, rd_data, rv;
	logic [4:0]  thr, main_lvl, ext_lvl;
	int          num_errors = 0;
	int          checks_done = 0;

	// design and comparator model
	supply_voltage_monitor_ctrl #(.PRESCALE(PS)) i_dut (.clk(clk), .rst_b(rst_b),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.cmp_below(below), .monitored_source_select(src), .threshold_level(thr),
		.comparator_enable(cmp_en), .low_voltage_irq(irq), .reset_req(rreq));
	supply_sense_model i_cmp (.clk(clk), .enable(cmp_en), .source_sel(src), .threshold(thr),
		.main_level(main_lvl), .ext_level(ext_lvl), .below(below));

	// clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// register port cycles and comparisons
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 rv = rd_data;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [1:0] a, input logic [15:0] exp);
		rd(a);
		chk(rv, exp);
	endtask
	task automatic poll_en(input logic v);
		int n;
		n = 0;
		do begin
			rd(ADDR_CTL);
			n++;
		end while (rv[CTL_EN] !== v && n < 50);
		chk({15'h0, rv[CTL_EN]}, {15'h0, v});
	endtask
	function automatic logic [15:0] ctl(logic s, logic [1:0] c, logic [4:0] t, logic [3:0] k,
		logic [1:0] m, logic e);
		return {s, c, t, k, 1'b0, m, e};
	endfunction
	task automatic results();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		results();
	end

	// main sequence
	initial begin
		logic [4:0] t;
		logic       s;
		logic [1:0] m;
		int         n;
		int         p;
		rst_b = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 2'h0;
		wr_data = 16'h0000;
		main_lvl = 5'h1f;
		ext_lvl = 5'h1f;
		void'($urandom(91));
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rdchk(ADDR_CTL, 16'h1e00);
		rdchk(ADDR_STS, 16'h0000);
		rdchk(ADDR_IEN, 16'h0000);
		wr(2'h3, 16'hffff);
		rdchk(2'h3, 16'h0000);
		rdchk(ADDR_IEN, 16'h0000);
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			t = (i == 0) ? 5'h01 : (i == 1) ? 5'h1e : 5'h01 + 5'($urandom_range(29));
			s = 1'($urandom_range(1));
			wr(ADDR_CTL, ctl(s, 2'h3, t, 4'h0, MODE_CONT, 1'b0));
			rdchk(ADDR_CTL, ctl(s, 2'h0, t, 4'h0, MODE_CONT, 1'b0));
			chk({10'h0, src, thr}, {10'h0, s, t});
		end
		$display("settings test done");
		wr(ADDR_CTL, ctl(1'b1, 2'h0, 5'h10, 4'h0, MODE_CONT, 1'b1));
		poll_en(1'b1);
		wr(ADDR_STS, 16'h0001);
		wr(ADDR_IEN, 16'h0001);
		main_lvl <= 5'h00;
		repeat (20) @(posedge clk);
		rdchk(ADDR_STS, 16'h0000);
		ext_lvl <= 5'h0f;
		repeat (20) @(posedge clk);
		rdchk(ADDR_STS, 16'h0101);
		chk({15'h0, irq}, 16'h0001);
		ext_lvl <= 5'h10;
		repeat (20) @(posedge clk);
		rdchk(ADDR_STS, 16'h0001);
		wr(ADDR_STS, 16'h0000);
		rdchk(ADDR_STS, 16'h0001);
		wr(ADDR_IEN, 16'h0000);
		repeat (3) @(posedge clk);
		chk({15'h0, irq}, 16'h0000);
		wr(ADDR_STS, 16'h0001);
		rdchk(ADDR_STS, 16'h0000);
		$display("continuous test done");
		for (int c = 0; c < 4; c++) begin
			m = 2'(1 + c % 3);
			n = 1 << c;
			p = PS * (64 << m);
			ext_lvl <= 5'h00;
			wr(ADDR_CTL, ctl(1'b1, 2'(c), 5'h10, 4'h0, m, 1'b1));
			repeat (10) @(posedge clk);
			wr(ADDR_STS, 16'h0001);
			repeat (n * p - p / 2) @(posedge clk);
			rdchk(ADDR_STS, 16'h0100);
			repeat (p) @(posedge clk);
			rdchk(ADDR_STS, 16'h0101);
		end
		$display("intermittent test done");
		ext_lvl <= 5'h1f;
		repeat (10) @(posedge clk);
		wr(ADDR_CTL, ctl(1'b1, 2'h0, 5'h10, RESET_KEY, MODE_CONT, 1'b1));
		wr(ADDR_STS, 16'h0001);
		wr(ADDR_IEN, 16'h0001);
		ext_lvl <= 5'h00;
		repeat (20) @(posedge clk);
		chk({14'h0, rreq, irq}, 16'h0002);
		rdchk(ADDR_IEN, 16'h0000);
		ext_lvl <= 5'h1f;
		repeat (20) @(posedge clk);
		chk({15'h0, rreq}, 16'h0000);
		$display("reset key test done");
		wr(ADDR_CTL, ctl(1'b1, 2'h0, 5'h10, 4'h0, MODE_CONT, 1'b0));
		poll_en(1'b0);
		ext_lvl <= 5'h00;
		repeat (10) @(posedge clk);
		rdchk(ADDR_STS, 16'h0001);
		chk({15'h0, cmp_en}, 16'h0000);
		wr(ADDR_STS, 16'h0001);
		wr(ADDR_CTL, ctl(1'b1, 2'h0, 5'h10, 4'h0, MODE_I128, 1'b1));
		poll_en(1'b1);
		wr(ADDR_CTL, ctl(1'b1, 2'h0, 5'h10, 4'h0, MODE_I128, 1'b0));
		poll_en(1'b0);
		rdchk(ADDR_STS, 16'h0000);
		rdchk(ADDR_CTL, ctl(1'b1, 2'h0, 5'h10, 4'h0, MODE_I128, 1'b0));
		$display("disable test done");
		results();
	end
endmodule
`default_nettype wire

//--- svm_monitor.sv
// assertion checker for the supply voltage monitor control block
`default_nettype none
module svm_monitor
	import svm_pkg::*;
#(
	parameter int unsigned PRESCALE = PRESCALE_DEF
) (
	// clock and reset
	input wire logic              clk,
	input wire logic              rst_b,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic              wr_en,
	input wire logic              rd_en,
	input wire logic [DATA_W-1:0] rd_data,
	// comparator side and requests
	input wire logic              cmp_below,
	input wire logic              monitored_source_select,
	input wire logic [4:0]        threshold_level,
	input wire logic              comparator_enable,
	input wire logic              low_voltage_irq,
	input wire logic              reset_req
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] wd_q;

	default clocking cb @(posedge clk); endclocking

	// write data of the previous cycle
	always_ff @(posedge clk) begin
		wd_q <= wr_data;
	end

	// all assertions
	a_reset_quiet:
	assert property (!rst_b |=> rd_data == '0 && !low_voltage_irq && !reset_req
		&& threshold_level == THR_RESET && !comparator_enable)
		else $error("outputs not idle after reset");
	a_read_slot:
	assert property (disable iff (!rst_b) !$past(rd_en) |-> rd_data == '0)
		else $error("read data outside its slot");
	a_unmapped_zero:
	assert property (disable iff (!rst_b) rd_en && addr == 2'h3 |=> rd_data == '0)
		else $error("unmapped read not zero");
	a_status_bits:
	assert property (disable iff (!rst_b) rd_en && addr == ADDR_STS |=> (rd_data & 16'hfefe) == '0)
		else $error("status reserved bits set");
	a_ien_bits:
	assert property (disable iff (!rst_b) rd_en && addr == ADDR_IEN |=> rd_data[15:1] == '0)
		else $error("irq enable reserved bits set");
	a_thr_follow:
	assert property (disable iff (!rst_b) wr_en && addr == ADDR_CTL && !reset_req
		|=> ##1 threshold_level == $past(wd_q[CTL_THR_LO +: 5])
		&& monitored_source_select == $past(wd_q[CTL_SRC]))
		else $error("threshold or source not taken");
	a_irq_gate:
	assert property (disable iff (!rst_b) wr_en && addr == ADDR_IEN && !wr_data[IEN_BIT]
		|=> ##1 !low_voltage_irq)
		else $error("irq while disabled");
	a_key_no_irq:
	assert property (disable iff (!rst_b) reset_req && $past(reset_req) |-> !low_voltage_irq)
		else $error("irq beside reset request");
	a_stop_cmp:
	assert property (disable iff (!rst_b) wr_en && addr == ADDR_CTL && !wr_data[CTL_EN]
		&& !reset_req |=> ##1 !comparator_enable)
		else $error("comparator still on after disable");
endmodule

bind supply_voltage_monitor_ctrl svm_monitor #(.PRESCALE(PRESCALE)) i_mon (.clk(clk),
	.rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .cmp_below(cmp_below), .monitored_source_select(monitored_source_select),
	.threshold_level(threshold_level), .comparator_enable(comparator_enable),
	.low_voltage_irq(low_voltage_irq), .reset_req(reset_req));
`default_nettype wire

//--- svm_pkg.sv
// constants for the supply voltage monitor control block
`default_nettype none
package svm_pkg;
	// ----------------------------------------------------------------
	// register map (word indices on the register port)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W   = 2;
	localparam int unsigned DATA_W   = 16;
	localparam logic [1:0]  ADDR_CTL = 2'h0;
	localparam logic [1:0]  ADDR_STS = 2'h1;
	localparam logic [1:0]  ADDR_IEN = 2'h2;

	// ----------------------------------------------------------------
	// control, status and interrupt enable register fields
	// ----------------------------------------------------------------
	localparam int unsigned CTL_SRC     = 15;
	localparam int unsigned CTL_CNT_LO  = 13;
	localparam int unsigned CTL_THR_LO  = 8;
	localparam int unsigned CTL_KEY_LO  = 4;
	localparam int unsigned CTL_MODE_LO = 1;
	localparam int unsigned CTL_EN      = 0;
	localparam int unsigned STS_BELOW   = 8;
	localparam int unsigned STS_FLAG    = 0;
	localparam int unsigned IEN_BIT     = 0;

	// ----------------------------------------------------------------
	// reset values and codes
	// ----------------------------------------------------------------
	localparam logic [4:0] THR_RESET   = 5'h1e;
	localparam logic [3:0] KEY_RESET   = 4'h0;
	localparam logic [3:0] RESET_KEY   = 4'ha;
	localparam logic [1:0] MODE_CONT   = 2'h0;
	localparam logic [1:0] MODE_I128   = 2'h1;
	localparam logic [1:0] MODE_I256   = 2'h2;
	localparam logic [1:0] MODE_I512   = 2'h3;
	localparam logic [1:0] CNT_RESET   = 2'h0;
	localparam logic [8:0] PERIOD_128  = 9'h07f;
	localparam logic [8:0] PERIOD_256  = 9'h0ff;
	localparam logic [8:0] PERIOD_512  = 9'h1ff;
	localparam logic [3:0] CNT_ONCE    = 4'h1;
	localparam logic [3:0] CNT_TWICE   = 4'h2;
	localparam logic [3:0] CNT_FOUR    = 4'h4;
	localparam logic [3:0] CNT_EIGHT   = 4'h8;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam longint unsigned CLK_HZ     = 250000000;
	localparam longint unsigned DET_CLK_HZ = 32768;
	localparam int unsigned PRESCALE_DEF   = int'(CLK_HZ / DET_CLK_HZ);
	localparam logic [1:0]  STOP_TICKS     = 2'h2;

	// enable sequencing states
	typedef enum logic [1:0] {
		ST_OFF,
		ST_RUN,
		ST_STOP
	} run_state_e;
endpackage
`default_nettype wire
